/* File: hw/nic_arbiter.sv */
`timescale 1ns/1ps
// Picks the enabled pending interrupt with the lowest priority value.
module nic_arbiter #(
  parameter int N = 30
) (
  input  wire logic [N-1:0]      cand,
  input  wire logic [N-1:0][3:0] prio,
  output logic                   found,
  output logic [4:0]             idx,
  output logic [3:0]             best
);

  // Scan upward with a strict compare so equal values keep the lower index.
  always_comb
  begin
    found = 1'b0;
    idx   = 5'h00;
    best  = 4'hF;
    for (int i = 0; i < N; i++)
    begin
      if (cand[i] && (!found || prio[i] < best))
      begin
        found = 1'b1;
        idx   = 5'(i);
        best  = prio[i];
      end
    end
  end

endmodule : nic_arbiter

/* File: hw/nic_map.svh */
`ifndef NIC_MAP_SVH
`define NIC_MAP_SVH

// Controller page and register offsets inside that page.
`define NIC_PAGE            20'hE000E
`define NIC_ENABLE_SET_BITS 12'h100
`define NIC_ENABLE_CLR_BITS 12'h180
`define NIC_PENDING_SET     12'h200
`define NIC_PENDING_CLR     12'h280
`define NIC_ACTIVE_FLAGS    12'h300
`define NIC_PRIORITY_FIELDS 12'h400
`define NIC_GROUP_CONFIG    12'h4E0
`define NIC_STATUS_WORD     12'h4E4
`define NIC_ARRAY_FIRST     12'h100
`define NIC_ARRAY_LAST      12'h4EF
`define NIC_SW_TRIGGER_WORD 12'hF00

// Sizes of the per-interrupt arrays.
`define NIC_NUM_IRQ         30
`define NIC_PRIO_WORDS      8

// Field positions and reset values.
`define NIC_TRIGGER_MSB     8
`define NIC_GROUP_MSB       2
`define NIC_PRIO_LSB        4
`define NIC_GROUP_RESET     3'h0
`define NIC_WORD_RESET      32'h00000000

`endif

/* File: hw/nic_nested_irq_controller.sv */
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "nic_map.svh"
// Operation
// (R1) Thirty lines, each enable/pending/active/priority
// (R2) Priority 0 to 15, zero most urgent
// (R3) Priority split into group and subpriority
// (R4) External non-maskable input accepted
// (R5) Core state saved and restored automatically
// (R6) Level source holds request until serviced
// (R7) High line while not active pends
// (R8) Rising edge on line pends
// (R9) Set-pending or trigger word pends
// (R10) Entry clears pending, marks active
// (R11) Exit resamples line: pending or inactive
// (R12) Clear-pending ignored while line high
// (R13) Pending recorded even when disabled
// (R14) Disable only blocks taking interrupt
// (R15) Misaligned accesses not decoded
// (R16) Decode array range and trigger word
// (R17) Privileged registers refuse unprivileged access
// (R18) One 4-bit priority per interrupt
// (R19) Enable-set: one enables, zero ignored
// (R20) Priority low nibble reads zero
// (R21) Active flag reads one while active
// (R22) Lowest value wins, lowest number ties
// (R23) Tail-chain into next handler on exit
module nic_nested_irq_controller #(
  parameter int N = `NIC_NUM_IRQ
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic [N-1:0]             irq_line,
  input  wire logic                     nmi_line,
  input  wire nic_pkg::nic_bus_req_type bus_req,
  output logic [31:0]                   rdata,
  output logic                          bus_err,
  input  wire nic_pkg::nic_core_evt_type core_evt,
  output nic_pkg::nic_core_req_type     core_req,
  output logic                          stack_save,
  output logic                          stack_restore,
  output logic                          tail_chain
);

  // Interrupt state, one bit or field per line, then the group setting, non-maskable and chain flags.
  logic [N-1:0]      enable, next_enable; // R1
  logic [N-1:0]      pending, next_pending;
  logic [N-1:0]      active, next_active;
  logic [N-1:0][3:0] prio, next_prio; // R2
  logic [N-1:0]      line_prev, next_line_prev;
  logic [2:0]        group_cfg, next_group_cfg;
  logic              nmi_prev, next_nmi_prev;
  logic              nmi_pend, next_nmi_pend;
  logic              nmi_act, next_nmi_act;
  logic              chained, next_chained;
  // Registered answers to the register port and to the core.
  logic [31:0]               next_rdata;
  logic                      next_bus_err;
  nic_pkg::nic_core_req_type next_core_req;
  logic                      next_stack_save;
  logic                      next_stack_restore;
  logic                      next_tail_chain;
  // Decode results for the current access.
  logic        in_page;      // Upper address bits select the page.
  logic        in_array;     // Offset lies in the main array range.
  logic        is_trigger;   // Offset selects the trigger word.
  logic        aligned;      // Address agrees with the access size.
  logic        word_ok;      // Full word access, needed outside priorities.
  logic        legal;        // Access is decoded and allowed.
  logic [11:0] offs;         // Byte offset within the page.
  logic [11:0] woffs;        // Word aligned offset.
  logic [3:0]  lanes;        // Byte lanes touched by the access.
  // Arbitration results.
  logic [N-1:0] cand;
  logic         found;
  logic [4:0]   win_idx;
  logic [3:0]   win_prio;
  logic [N-1:0] enter_mask, exit_mask, rise;
  // Group mask keeps the group part of a priority under the split setting.
  function automatic logic [3:0] group_mask(input logic [2:0] cfg);
    if (cfg <= 3'h3)
      return 4'hF;
    return 4'(4'hF << (cfg - 3'h3));
  endfunction : group_mask
  // Most urgent group among the handlers still active, 4'hF+ when none.
  function automatic logic [4:0] running(input logic [N-1:0] act,
                                         input logic [N-1:0][3:0] pr,
                                         input logic [2:0] cfg);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 0; i < N; i++)
    begin
      if (act[i] && {1'b0, pr[i] & group_mask(cfg)} < r)
        r = {1'b0, pr[i] & group_mask(cfg)};
    end
    return r;
  endfunction : running
  // Lane mask from size and the low address bits.
  function automatic logic [3:0] lane_mask(input nic_pkg::nic_size_type s,
                                           input logic [1:0] a);
    unique case (s)
      nic_pkg::NIC_SIZE_BYTE: return 4'(4'h1 << a);
      nic_pkg::NIC_SIZE_HALF: return a[1] ? 4'hC : 4'h3;
      nic_pkg::NIC_SIZE_WORD: return 4'hF;
      nic_pkg::NIC_SIZE_NONE: return 4'h0;
    endcase
  endfunction : lane_mask
  // The disabled lines are left out here and nowhere else.
  assign cand = pending & enable; // R13 R14

  nic_arbiter #(.N (N)) u_arbiter (.cand (cand), .prio (prio), .found (found),
                                   .idx (win_idx), .best (win_prio)); // R22

  // Address decode; anything else answers zero with the error flag.
  always_comb
  begin
    offs       = bus_req.addr[11:0];
    woffs      = {offs[11:2], 2'b00};
    in_page    = bus_req.addr[31:12] == `NIC_PAGE; // R16
    in_array   = in_page && offs >= `NIC_ARRAY_FIRST
                 && offs <= `NIC_ARRAY_LAST; // R16
    is_trigger = in_page && woffs == `NIC_SW_TRIGGER_WORD; // R16
    lanes      = lane_mask(bus_req.size, offs[1:0]);
    aligned    = bus_req.size != nic_pkg::NIC_SIZE_NONE
                 && !(bus_req.size == nic_pkg::NIC_SIZE_HALF && offs[0])
                 && !(bus_req.size == nic_pkg::NIC_SIZE_WORD
                      && offs[1:0] != 2'b00); // R15
    word_ok    = bus_req.size == nic_pkg::NIC_SIZE_WORD
                 || (woffs >= `NIC_PRIORITY_FIELDS
                     && woffs < `NIC_PRIORITY_FIELDS + 12'h020);
    // The trigger word alone is open to unprivileged code.
    legal      = aligned && word_ok
                 && ((in_array && bus_req.priv) || is_trigger); // R17
  end

  // Core events turned into per-line masks.
  always_comb
  begin
    enter_mask = '0;
    exit_mask  = '0;
    if (core_evt.enter && !core_evt.nmi && core_evt.num < 5'(N))
      enter_mask[core_evt.num] = 1'b1;
    if (core_evt.exit && !core_evt.nmi && core_evt.num < 5'(N))
      exit_mask[core_evt.num] = 1'b1;
    rise = irq_line & ~line_prev;
  end

  // Next state of all interrupt bookkeeping and of the software writes.
  // Hardware sets are applied last so a clear in the same cycle never
  // swallows a fresh event.
  always_comb
  begin
    logic [N-1:0] set_p;
    logic [N-1:0] clr_p;
    set_p          = '0;
    clr_p          = '0;
    next_enable    = enable;
    next_prio      = prio;
    next_group_cfg = group_cfg;
    next_line_prev = irq_line;
    next_nmi_prev  = nmi_line;
    next_active    = (active | enter_mask) & ~exit_mask; // R10 R11
    if (bus_req.wr && legal)
    begin
      unique case (woffs)
        `NIC_ENABLE_SET_BITS:
          next_enable = enable | bus_req.wdata[N-1:0]; // R19
        `NIC_ENABLE_CLR_BITS:
          next_enable = enable & ~bus_req.wdata[N-1:0]; // R14
        `NIC_PENDING_SET:
          set_p = bus_req.wdata[N-1:0]; // R9
        `NIC_PENDING_CLR:
          clr_p = bus_req.wdata[N-1:0] & ~irq_line; // R12
        `NIC_GROUP_CONFIG:
          next_group_cfg = bus_req.wdata[`NIC_GROUP_MSB:0]; // R3
        `NIC_SW_TRIGGER_WORD:
          if (bus_req.wdata[`NIC_TRIGGER_MSB:0] < 9'(N))
            set_p[bus_req.wdata[4:0]] = 1'b1; // R9
        default:
          // Priority words take each written lane's upper nibble.
          for (int i = 0; i < N; i++)
          begin
            if (woffs == `NIC_PRIORITY_FIELDS + 12'(4 * (i / 4))
                && lanes[i % 4])
              next_prio[i] = bus_req.wdata[8 * (i % 4) + `NIC_PRIO_LSB +: 4];
          end // R18 R20
      endcase
    end
    // Entry drops pending; exit with the line still high pends again.
    next_pending = (pending & ~clr_p & ~enter_mask) | set_p
                   | (irq_line & exit_mask) // R11
                   | (irq_line & ~active & ~enter_mask) // R7
                   | rise; // R8
    // The non-maskable source pends on its rising edge.
    next_nmi_pend = (nmi_pend && !(core_evt.enter && core_evt.nmi))
                    || (nmi_line && !nmi_prev); // R4
    next_nmi_act  = (nmi_act || (core_evt.enter && core_evt.nmi))
                    && !(core_evt.exit && core_evt.nmi); // R4
  end

  // Register read data; unused bits and unimplemented words read zero.
  always_comb
  begin
    next_rdata   = `NIC_WORD_RESET;
    next_bus_err = (bus_req.wr || bus_req.rd) && !legal;
    if (bus_req.rd && legal)
    begin
      unique case (woffs)
        `NIC_ENABLE_SET_BITS, `NIC_ENABLE_CLR_BITS:
          next_rdata[N-1:0] = enable;
        `NIC_PENDING_SET, `NIC_PENDING_CLR:
          next_rdata[N-1:0] = pending;
        `NIC_ACTIVE_FLAGS:
          next_rdata[N-1:0] = active; // R21
        `NIC_GROUP_CONFIG:
          next_rdata[`NIC_GROUP_MSB:0] = group_cfg;
        `NIC_STATUS_WORD:
          next_rdata[10:0] = {nmi_act, nmi_pend, found, win_prio,
                              win_idx[4:1]};
        default:
          for (int i = 0; i < N; i++)
          begin
            if (woffs == `NIC_PRIORITY_FIELDS + 12'(4 * (i / 4)))
              next_rdata[8 * (i % 4) + `NIC_PRIO_LSB +: 4] = prio[i];
          end // R20
      endcase
    end
  end

  // Core side: present the winner when it may preempt what is running,
  // and decide between unstacking and chaining when a handler ends.
  // The non-maskable request outranks every peripheral line.
  always_comb
  begin
    logic [4:0] run_now;
    logic [4:0] run_after;
    logic [3:0] win_grp;
    win_grp   = win_prio & group_mask(group_cfg); // R3
    run_now   = running(active, prio, group_cfg);
    run_after = running(active & ~exit_mask, prio, group_cfg);
    next_core_req       = '0;
    next_stack_save     = 1'b0;
    next_stack_restore  = 1'b0;
    next_tail_chain     = 1'b0;
    next_chained        = chained;
    if (nmi_pend && !nmi_act)
    begin
      next_core_req.valid = 1'b1; // R4
      next_core_req.nmi   = 1'b1;
    end
    else if (found && !nmi_act && {1'b0, win_grp} < run_now)
    begin
      next_core_req.valid = 1'b1; // R22
      next_core_req.num   = win_idx;
      next_core_req.grp   = win_grp;
    end
    if (core_evt.enter)
    begin
      // A chained entry reuses the frame already on the stack.
      next_stack_save = !chained; // R5
      next_chained    = 1'b0;
    end
    else if (core_evt.exit)
    begin
      if (found && {1'b0, win_grp} < run_after && !core_evt.nmi)
      begin
        next_tail_chain = 1'b1; // R23
        next_chained    = 1'b1;
      end
      else
        next_stack_restore = 1'b1; // R5
    end
  end

  // State flip-flops only take the values worked out above.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enable        <= '0;
      pending       <= '0;
      active        <= '0;
      prio          <= '0;
      line_prev     <= '0;
      group_cfg     <= `NIC_GROUP_RESET;
      nmi_prev      <= 1'b0;
      nmi_pend      <= 1'b0;
      nmi_act       <= 1'b0;
      chained       <= 1'b0;
      rdata         <= `NIC_WORD_RESET;
      bus_err       <= 1'b0;
      core_req      <= '0;
      stack_save    <= 1'b0;
      stack_restore <= 1'b0;
      tail_chain    <= 1'b0;
    end
    else
    begin
      enable        <= next_enable;
      pending       <= next_pending;
      active        <= next_active;
      prio          <= next_prio;
      line_prev     <= next_line_prev;
      group_cfg     <= next_group_cfg;
      nmi_prev      <= next_nmi_prev;
      nmi_pend      <= next_nmi_pend;
      nmi_act       <= next_nmi_act;
      chained       <= next_chained;
      rdata         <= next_rdata;
      bus_err       <= next_bus_err;
      core_req      <= next_core_req;
      stack_save    <= next_stack_save;
      stack_restore <= next_stack_restore;
      tail_chain    <= next_tail_chain;
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_edge_pends: // R8
    assert property (rise != '0 |=> (pending & $past(rise)) == $past(rise))
      else $error("rising edge did not pend");
  a_level_pends: // R7
    assert property (1'b1 |=> ($past(irq_line & ~active & ~enter_mask)
                     & ~pending) == '0)
      else $error("high line did not pend");
  a_entry_active: // R10
    assert property (enter_mask != '0 |=> (active & $past(enter_mask))
                     == $past(enter_mask))
      else $error("entry did not mark active");
  a_exit_resample: // R11
    assert property ((exit_mask & irq_line) != '0 |=>
                     (pending & $past(exit_mask)) != '0)
      else $error("exit with line high did not pend");
  a_swset_pends: // R9
    assert property (bus_req.wr && legal && woffs == `NIC_PENDING_SET
                     |=> (pending & $past(bus_req.wdata[N-1:0]))
                     == $past(bus_req.wdata[N-1:0]))
      else $error("set-pending write lost");
  a_clr_holds: // R12
    assert property (bus_req.wr && legal && woffs == `NIC_PENDING_CLR
                     |=> (($past(bus_req.wdata[N-1:0] & irq_line & pending))
                     & ~pending) == '0)
      else $error("clear-pending dropped a held line");
  a_req_enabled: // R14
    assert property (core_req.valid && !core_req.nmi
                     |-> ($past(enable) & (N'(1) << core_req.num)) != '0)
      else $error("disabled line presented");
  a_prio_nibble: // R20
    assert property (bus_req.rd && woffs >= `NIC_PRIORITY_FIELDS &&
                     woffs < `NIC_GROUP_CONFIG |=> (rdata & 32'h0F0F0F0F) == '0)
      else $error("priority low nibble not zero");
  a_unpriv_block: // R17
    assert property (bus_req.wr && !bus_req.priv && !is_trigger
                     |=> bus_err && enable == $past(enable))
      else $error("unprivileged write took effect");
  a_misalign_err: // R15
    assert property ((bus_req.wr || bus_req.rd) && !aligned |=> bus_err)
      else $error("misaligned access not refused");

  c_chain:   cover property (tail_chain);
  c_nmi:     cover property (core_req.valid && core_req.nmi);
  c_reenter: cover property ((exit_mask & irq_line) != '0);
  c_trigger: cover property (bus_req.wr && is_trigger && legal);

endmodule : nic_nested_irq_controller

/* File: hw/nic_pkg.sv */
package nic_pkg;

  // Access size on the register port.
  typedef enum logic [1:0] {
    NIC_SIZE_BYTE,
    NIC_SIZE_HALF,
    NIC_SIZE_WORD,
    NIC_SIZE_NONE
  } nic_size_type;

  // One register request from software.
  typedef struct packed {
    logic [31:0]  addr;
    logic [31:0]  wdata;
    logic         wr;
    logic         rd;
    nic_size_type size;
    logic         priv;
  } nic_bus_req_type;

  // Exception sequencing events reported by the core.
  typedef struct packed {
    logic       enter;
    logic       exit;
    logic       nmi;
    logic [4:0] num;
  } nic_core_evt_type;

  // Request presented to the core.
  typedef struct packed {
    logic       valid;
    logic       nmi;
    logic [4:0] num;
    logic [3:0] grp;
  } nic_core_req_type;

endpackage : nic_pkg

/* File: sim/nested_interrupt_controller_tb.sv */
`timescale 1ns/1ps
`include "nic_map.svh"
// Register-level and core-level checks of the interrupt controller.
module nested_interrupt_controller_tb;
  localparam logic [11:0] ENS = `NIC_ENABLE_SET_BITS;
  localparam logic [11:0] ENC = `NIC_ENABLE_CLR_BITS;
  localparam logic [11:0] PDS = `NIC_PENDING_SET;
  localparam logic [11:0] PDC = `NIC_PENDING_CLR;
  localparam logic [11:0] ACT = `NIC_ACTIVE_FLAGS;
  localparam logic [11:0] PRI = `NIC_PRIORITY_FIELDS;
  localparam logic [11:0] TRG = `NIC_SW_TRIGGER_WORD;
  localparam logic [11:0] GRP = `NIC_GROUP_CONFIG;
  localparam nic_pkg::nic_size_type W = nic_pkg::NIC_SIZE_WORD;
  localparam nic_pkg::nic_size_type B = nic_pkg::NIC_SIZE_BYTE;

  logic                      clk;
  logic                      rstn;
  logic [29:0]               irq_line;
  logic                      nmi_line;
  logic                      go;
  nic_pkg::nic_bus_req_type  bus_req;
  logic [31:0]               rdata;
  logic                      bus_err;
  nic_pkg::nic_core_evt_type core_evt;
  nic_pkg::nic_core_req_type core_req;
  logic                      stack_save;
  logic                      stack_restore;
  logic                      tail_chain;
  int                        num_errors;
  int                        num_checks;
  int                        n_pulse [3]; // Save, restore, chain counts.

  nic_nested_irq_controller #(.N(30)) i_dut (
    .clk(clk), .rstn(rstn), .irq_line(irq_line), .nmi_line(nmi_line),
    .bus_req(bus_req), .rdata(rdata), .bus_err(bus_err),
    .core_evt(core_evt), .core_req(core_req), .stack_save(stack_save),
    .stack_restore(stack_restore), .tail_chain(tail_chain)
  );

  nic_core_model i_core (
    .clk(clk), .rstn(rstn), .go(go), .core_req(core_req),
    .core_evt(core_evt)
  );

  // Free-running 125 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pulses are counted so sequencing can be judged after the fact.
  always @(posedge clk)
  begin
    n_pulse[0] += (stack_save === 1'b1);
    n_pulse[1] += (stack_restore === 1'b1);
    n_pulse[2] += (tail_chain === 1'b1);
  end

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One register access; the answer is judged in the following cycle.
  task automatic acc(input logic w, input logic [11:0] off,
                     input logic [31:0] data, input nic_pkg::nic_size_type sz,
                     input logic pv, input logic [31:0] exp, input logic err);
    @(posedge clk);
    bus_req <= '{addr: {`NIC_PAGE, off}, wdata: data, wr: w, rd: !w,
                 size: sz, priv: pv};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
    chk(bus_err, err);
  endtask : acc

  // Bounded wait for a pulse count; index 3 sums restore and chain.
  task automatic wait_pulse(input int k, input int v);
    int i;
    for (i = 0; i < 300; i++)
    begin
      if ((k == 3 ? n_pulse[1] + n_pulse[2] : n_pulse[k]) >= v)
        return;
      @(posedge clk);
    end
    num_errors++;
    summarize();
  endtask : wait_pulse

  // A hung run is cut short and judged as failed.
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end

  initial
  begin
    num_errors = 0;
    num_checks = 0;
    n_pulse    = '{0, 0, 0};
    rstn       = 1'b0;
    irq_line   = '0;
    nmi_line   = 1'b0;
    go         = 1'b0;
    bus_req    = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, enable set and clear.
    acc(0, ENS, 0, W, 1, 32'h00000000, 0);
    acc(0, PRI, 0, W, 1, 32'h00000000, 0);
    acc(1, ENS, 32'h000000A0, W, 1, 0, 0);
    acc(1, ENS, 32'h00000000, W, 1, 0, 0);
    acc(0, ENS, 0, W, 1, 32'h000000A0, 0);
    acc(1, ENC, 32'h00000020, W, 1, 0, 0);
    acc(0, ENS, 0, W, 1, 32'h00000080, 0);
    // Priority nibbles and byte lanes.
    acc(1, PRI + 12'h004, 32'hFFFFFFFF, W, 1, 0, 0);
    acc(0, PRI + 12'h004, 0, W, 1, 32'hF0F0F0F0, 0);
    acc(1, PRI + 12'h005, 32'h00002000, B, 1, 0, 0);
    acc(0, PRI + 12'h004, 0, W, 1, 32'hF0F020F0, 0);
    acc(1, PRI + 12'h004, 32'h00000000, W, 1, 0, 0);
    // Refused accesses.
    acc(0, PRI + 12'h002, 0, W, 1, 0, 1);
    acc(0, ENS, 0, B, 1, 0, 1);
    acc(0, ENS, 0, W, 0, 0, 1);
    acc(1, ENS, 32'h00000001, W, 0, 0, 1);
    acc(0, 12'h000, 0, W, 1, 0, 1);
    acc(0, 12'h4F0, 0, W, 1, 0, 1);
    // Software trigger from unprivileged code, pending while disabled.
    acc(1, TRG, 32'h00000009, W, 0, 0, 0);
    irq_line[11] <= 1'b1; // Source holds its request.
    acc(0, PDS, 0, W, 1, 32'h00000A00, 0);
    chk(core_req.valid, 1'b0);
    acc(1, PDC, 32'h00000A00, W, 1, 0, 0);
    acc(0, PDS, 0, W, 1, 32'h00000800, 0);
    irq_line[11] <= 1'b0;
    acc(1, PDC, 32'h00000800, W, 1, 0, 0);
    acc(0, PDS, 0, W, 1, 32'h00000000, 0);
    // Arbitration: tie to the lower number, then by priority value.
    acc(1, PDS, 32'h000000A0, W, 1, 0, 0);
    acc(1, ENS, 32'h00000020, W, 1, 0, 0);
    repeat (2) @(posedge clk);
    #1;
    chk({core_req.valid, core_req.nmi, core_req.num}, 7'h45);
    acc(1, PRI + 12'h005, 32'h00004000, B, 1, 0, 0);
    repeat (2) @(posedge clk);
    #1;
    chk({core_req.valid, core_req.nmi, core_req.num}, 7'h47);
    // Service 7, then chain into 5 without a second save.
    go <= 1'b1;
    wait_pulse(0, 1);
    acc(0, ACT, 0, W, 1, 32'h00000080, 0);
    acc(0, PDS, 0, W, 1, 32'h00000020, 0);
    wait_pulse(1, 1);
    chk(n_pulse[0], 1);
    chk(n_pulse[2], 1);
    acc(0, ACT, 0, W, 1, 32'h00000000, 0);
    // A level request still high at exit pends again.
    go <= 1'b0;
    acc(1, ENS, 32'h00000800, W, 1, 0, 0);
    irq_line[11] <= 1'b1;
    go <= 1'b1;
    wait_pulse(0, 2);
    go <= 1'b0;
    wait_pulse(3, 3);
    acc(0, PDS, 0, W, 1, 32'h00000800, 0);
    irq_line[11] <= 1'b0; // Handler has cleared the cause.
    acc(1, PDC, 32'h00000800, W, 1, 0, 0);
    acc(0, PDS, 0, W, 1, 32'h00000000, 0);
    // Split setting 5 keeps the upper two bits of level 0xB as group 8.
    acc(1, PRI + 12'h00B, 32'hB0000000, B, 1, 0, 0);
    acc(1, GRP, 32'h00000005, W, 1, 0, 0);
    acc(0, GRP, 0, W, 1, 32'h00000005, 0);
    acc(1, PDS, 32'h00000800, W, 1, 0, 0);
    repeat (2) @(posedge clk);
    #1;
    chk({core_req.valid, core_req.nmi, core_req.num, core_req.grp},
        11'h4B8);
    // Non-maskable request on a rising edge.
    nmi_line <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({core_req.valid, core_req.nmi}, 2'h3);
    summarize();
  end
endmodule : nested_interrupt_controller_tb

/* File: sim/nic_core_model.sv */
`timescale 1ns/1ps
// Behavioural core: takes the presented request, runs a handler, returns.
module nic_core_model #(
  parameter int LAT     = 2,
  parameter int SERVICE = 30
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      go,
  input  wire nic_pkg::nic_core_req_type core_req,
  output nic_pkg::nic_core_evt_type      core_evt
);
  logic [1:0] phase; // Idle, waiting, in handler, cooling down.
  logic [7:0] cnt;   // Cycles left in the current phase.

  // Entry is dropped if the request vanishes while the core is slow.
  // The cool-down lets the registered request settle after an exit.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase    <= 2'h0;
      cnt      <= 8'h00;
      core_evt <= '0;
    end
    else
    begin
      core_evt.enter <= 1'b0;
      core_evt.exit  <= 1'b0;
      cnt            <= cnt - 8'h01;
      case (phase)
        2'h0: if (go && core_req.valid === 1'b1)
        begin
          phase <= 2'h1;
          cnt   <= 8'(LAT);
        end
        2'h1: if (core_req.valid !== 1'b1)
          phase <= 2'h0;
        else if (cnt == 8'h00)
        begin
          core_evt.enter <= 1'b1;
          core_evt.num   <= core_req.num;
          core_evt.nmi   <= core_req.nmi;
          phase          <= 2'h2;
          cnt            <= 8'(SERVICE);
        end
        2'h2: if (cnt == 8'h00)
        begin
          core_evt.exit <= 1'b1; // Exit names the number it entered.
          phase         <= 2'h3;
          cnt           <= 8'h03;
        end
        default: if (cnt == 8'h00)
          phase <= 2'h0;
      endcase
    end
  end
endmodule : nic_core_model
